// ---- rtl/qsf_pkg.sv ----
// Package for the quad serial flash control block.
// Assumes a single 25 MHz clock that serves as both bus and base clock.
package qsf_pkg;
	localparam int CLK_NS = 40;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 16;
	localparam int DIV_W = 11;
	localparam int THR_W = 8;
	localparam int BYTE_W = 8;
	localparam int QDEPTH = 8;
	// Register indices
	localparam logic [1:0] IDX_XCTL = 2'h0;
	localparam logic [1:0] IDX_CKCTL = 2'h1;
	localparam logic [1:0] IDX_THR = 2'h2;
	// transfer_control fields
	localparam int CTL_CNT_LSB = 0;
	localparam int CTL_MODE_LSB = 16;
	localparam int CTL_LANE_LSB = 18;
	localparam int CTL_TSEL_LSB = 20;
	localparam int CTL_REL_BIT = 22;
	localparam int CTL_CHK_BIT = 24;
	// serial_clock_control fields
	localparam int CK_EN_BIT = 0;
	localparam int CK_STB_BIT = 1;
	localparam int CK_DIV_LSB = 8;
	// command_threshold fields
	localparam int THR_RX_LSB = 0;
	localparam int THR_TX_LSB = 8;
	// Reset values
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [DIV_W-1:0] DIV_RST = 11'h000;
	localparam logic [THR_W-1:0] THR_RST = 8'h00;
	// Encodings
	localparam logic [1:0] IMODE_IDLE = 2'h0;
	localparam logic [1:0] IMODE_TX = 2'h1;
	localparam logic [1:0] IMODE_RX = 2'h2;
	localparam logic [1:0] LANE_1 = 2'h0;
	localparam logic [1:0] LANE_2 = 2'h1;
	localparam logic [1:0] LANE_4 = 2'h2;
	localparam logic [1:0] TSEL_DEV0 = 2'h0;
	localparam logic [1:0] TSEL_DEV1 = 2'h1;
	localparam logic [1:0] CS_NONE = 2'h3;
	localparam logic [BYTE_W-1:0] STAT_CMD = 8'h05;
	localparam int STAT_BUSY_BIT = 0;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_XFER = 4'h2,
		ST_POLL_CMD = 4'h4,
		ST_POLL_DATA = 4'h8
	} eng_state_t;
endpackage

// ---- rtl/quad_serial_flash_control.sv ----
// Quad serial flash control: registers, clock divider, byte engine, queues.
// Assumes the flash sits on SQD pins; TX/RX streams come from same-clock logic.

// Shift-down queue; head word and both handshakes come from flip-flops.
module byte_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int LW = $clog2(DEPTH + 1)
) (
	input wire logic clk_in, // Clock
	input wire logic rst_in, // Async reset, high
	input wire logic [WIDTH-1:0] in_data_in, // Word to store
	input wire logic in_valid_in, // Word offered
	output logic in_ready_out, // Room for a word
	output logic [WIDTH-1:0] out_data_out, // Head word
	output logic out_valid_out, // Head word present
	input wire logic out_ready_in, // Head word taken
	output logic [LW-1:0] level_out // Words held
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [LW-1:0] cnt_r, cnt_nxt, wr_idx;
	logic push, pop;

	always_comb begin
		push = in_valid_in && in_ready_out;
		pop = out_valid_out && out_ready_in;
		wr_idx = pop ? cnt_r - 1'b1 : cnt_r;
		cnt_nxt = cnt_r + LW'(push) - LW'(pop);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= '0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			in_ready_out <= cnt_nxt != LW'(DEPTH);
			out_valid_out <= cnt_nxt != '0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (push && wr_idx == LW'(i)) begin
					mem_r[i] <= in_data_in;
				end else if (pop && i < DEPTH - 1) begin
					mem_r[i] <= mem_r[i + 1];
				end
			end
		end
	end

	assign out_data_out = mem_r[0];
	assign level_out = cnt_r;
endmodule // byte_queue

// Notes on behaviour
// - Status-check bit set makes the engine poll flash status after a released frame.
// - Release-policy 1 drops chip select after the count; 0 keeps it asserted.
// - Target select 00 drives device 0, 01 device 1; 10 and 11 reserved.
// - Lane width 00 single, 01 dual, 10 quad; 11 reserved, never used.
// - Transmit mode starts commands from data written into the transmit queue.
// - Receive mode starts commands when reads free space in the receive queue.
// - Idle initiation mode starts nothing; code 11 is reserved.
// - Sixteen-bit byte count gives the bytes to move, direction from the mode.
// - One-hot divider picks a power-of-two ratio from 2 to 2048.
// - Divider value zero gives the fastest serial clock.
// - Stable flag rises once the enabled serial clock has settled, else reads 0.
// - Clearing clock enable stops the serial clock; registers stay accessible.
// - Transmit starts once the transmit queue holds the transmit threshold.
// - Receive starts while the receive queue holds fewer than the receive threshold and never starts without room.
module quad_serial_flash_control
	import qsf_pkg::*;
#(
	parameter int DEPTH = QDEPTH,
	parameter int SETTLE = SETTLE_CYC
) (
	input wire logic CLOCK_IN, // Bus and base clock
	input wire logic RST_IN, // Async reset, high
	input wire logic REG_WR_IN, // Register write strobe
	input wire logic REG_RD_IN, // Register read strobe
	input wire logic [1:0] REG_ADDR_IN, // Register index
	input wire logic [31:0] REG_WDATA_IN, // Write data
	output logic [31:0] REG_RDATA_OUT, // Read data
	input wire logic [7:0] TX_DATA_IN, // Transmit byte
	input wire logic TX_VALID_IN, // Transmit byte offered
	output logic TX_READY_OUT, // Transmit queue has room
	output logic [7:0] RX_DATA_OUT, // Received byte
	output logic RX_VALID_OUT, // Received byte present
	input wire logic RX_READY_IN, // Received byte taken
	output logic SCK_OUT, // Serial clock
	output logic CS0_N_OUT, // Device 0 select, low
	output logic CS1_N_OUT, // Device 1 select, low
	input wire logic [3:0] SQD_IN, // Data lanes in
	output logic [3:0] SQD_OUT, // Data lanes out
	output logic [3:0] SQD_OE_OUT, // Data lane drive enables
	output logic BUSY_OUT // Engine active
);
	localparam int LW = $clog2(DEPTH + 1);
	localparam int SW = $clog2(SETTLE + 1);

	logic [CNT_W-1:0] byte_count_r;
	logic [1:0] init_mode_r, lane_width_r, target_sel_r;
	logic cs_release_r, status_check_r;
	logic [DIV_W-1:0] div_r, hp_cnt_r, hp_w;
	logic clk_en_r, clk_stable_r, tick_w;
	logic [SW-1:0] stab_cnt_r;
	logic [THR_W-1:0] tx_thr_r, rx_thr_r;
	logic [3:0] sqd_meta_r, sqd_sync_r, step_w;
	eng_state_t st_r;
	logic sck_r, dev_r, dir_rx_r;
	logic [1:0] cs_n_r, lanes_r;
	logic [BYTE_W-1:0] sh_r, sh_nxt, shifted_w, tx_q_data;
	logic [3:0] bit_cnt_r, sqd_o_r, sqd_oe_r;
	logic [CNT_W-1:0] bytes_left_r;
	logic [31:0] rdata_r;
	logic busy_r, cs_act_w, at_gap_w, rising_w, falling_w, legal_w, start_w;
	logic tx_go_w, rx_go_w, xfer_load_w, poll_load_w, end_w;
	logic tx_q_valid, tx_pop_w, rx_push_w, rx_in_ready;
	logic [LW-1:0] tx_level, rx_level;

	// Half period in base clocks of the highest set divider bit
	function automatic logic [DIV_W-1:0] half_cycles(input logic [DIV_W-1:0] d);
		half_cycles = DIV_W'(1);
		for (int i = 0; i < DIV_W; i++) begin
			if (d[i]) begin
				half_cycles = DIV_W'(1) << i;
			end
		end
	endfunction

	function automatic logic [3:0] lane_step(input logic [1:0] l);
		case (l)
			LANE_2: lane_step = 4'h2;
			LANE_4: lane_step = 4'h4;
			default: lane_step = 4'h1;
		endcase
	endfunction

	function automatic logic [3:0] lane_bits(input logic [1:0] l, input logic [7:0] s);
		case (l)
			LANE_2: lane_bits = {2'h0, s[7:6]};
			LANE_4: lane_bits = s[7:4];
			default: lane_bits = {3'h0, s[7]};
		endcase
	endfunction

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			byte_count_r <= CNT_RST;
			init_mode_r <= IMODE_IDLE;
			lane_width_r <= LANE_1;
			target_sel_r <= TSEL_DEV0;
			cs_release_r <= 1'b0;
			status_check_r <= 1'b0;
			div_r <= DIV_RST;
			clk_en_r <= 1'b0;
			tx_thr_r <= THR_RST;
			rx_thr_r <= THR_RST;
		end else if (REG_WR_IN) begin
			case (REG_ADDR_IN)
				IDX_XCTL: begin
					byte_count_r <= REG_WDATA_IN[CTL_CNT_LSB +: CNT_W];
					init_mode_r <= REG_WDATA_IN[CTL_MODE_LSB +: 2];
					lane_width_r <= REG_WDATA_IN[CTL_LANE_LSB +: 2];
					target_sel_r <= REG_WDATA_IN[CTL_TSEL_LSB +: 2];
					cs_release_r <= REG_WDATA_IN[CTL_REL_BIT];
					status_check_r <= REG_WDATA_IN[CTL_CHK_BIT];
				end
				IDX_CKCTL: begin
					div_r <= REG_WDATA_IN[CK_DIV_LSB +: DIV_W];
					clk_en_r <= REG_WDATA_IN[CK_EN_BIT];
				end
				IDX_THR: begin
					tx_thr_r <= REG_WDATA_IN[THR_TX_LSB +: THR_W];
					rx_thr_r <= REG_WDATA_IN[THR_RX_LSB +: THR_W];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			rdata_r <= 32'h0000_0000;
		end else if (REG_RD_IN) begin
			case (REG_ADDR_IN)
				IDX_XCTL: rdata_r <= {7'h00, status_check_r, 1'b0, cs_release_r,
					target_sel_r, lane_width_r, init_mode_r, byte_count_r};
				IDX_CKCTL: rdata_r <= {13'h0000, div_r, 6'h00, clk_stable_r, clk_en_r};
				IDX_THR: rdata_r <= {16'h0000, tx_thr_r, rx_thr_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sqd_meta_r <= 4'h0;
			sqd_sync_r <= 4'h0;
		end else begin
			sqd_meta_r <= SQD_IN;
			sqd_sync_r <= sqd_meta_r;
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			stab_cnt_r <= '0;
			clk_stable_r <= 1'b0;
		end else if (!clk_en_r) begin
			stab_cnt_r <= '0;
			clk_stable_r <= 1'b0;
		end else if (stab_cnt_r == SW'(SETTLE)) begin
			clk_stable_r <= 1'b1;
		end else begin
			stab_cnt_r <= stab_cnt_r + 1'b1;
		end
	end

	// power-of-two half period
	// Phase held in idle so the first rise sees synced lane input
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			hp_cnt_r <= '0;
		end else if (!clk_stable_r || tick_w || st_r == ST_IDLE) begin
			hp_cnt_r <= '0;
		end else begin
			hp_cnt_r <= hp_cnt_r + 1'b1;
		end
	end

	always_comb begin
		hp_w = half_cycles(div_r);
		tick_w = clk_stable_r && (hp_cnt_r >= hp_w - 1'b1);
		step_w = lane_step(lanes_r);
		cs_act_w = cs_n_r != CS_NONE;
		at_gap_w = (st_r != ST_IDLE) && !sck_r && (bit_cnt_r == 4'h0);
		rising_w = (st_r != ST_IDLE) && tick_w && !sck_r && (bit_cnt_r != 4'h0);
		falling_w = tick_w && sck_r;
		case (lanes_r)
			LANE_2: shifted_w = {sh_r[5:0], sqd_sync_r[1:0]};
			LANE_4: shifted_w = {sh_r[3:0], sqd_sync_r};
			default: shifted_w = {sh_r[6:0], sqd_sync_r[1]};
		endcase
		// byte loads and end of count
		xfer_load_w = (st_r == ST_XFER) && at_gap_w && (bytes_left_r != '0) &&
			(dir_rx_r ? rx_in_ready : tx_q_valid);
		poll_load_w = (st_r == ST_POLL_CMD || st_r == ST_POLL_DATA) && at_gap_w &&
			(bytes_left_r != '0) && cs_act_w;
		end_w = (st_r == ST_XFER) && at_gap_w && (bytes_left_r == '0);
		tx_pop_w = xfer_load_w && !dir_rx_r;
		rx_push_w = (st_r == ST_XFER) && dir_rx_r && rising_w && (bit_cnt_r == step_w);
		legal_w = (target_sel_r == TSEL_DEV0 || target_sel_r == TSEL_DEV1) &&
			(lane_width_r == LANE_1 || lane_width_r == LANE_2 || lane_width_r == LANE_4);
		tx_go_w = (init_mode_r == IMODE_TX) && (THR_W'(tx_level) >= tx_thr_r) &&
			(tx_level != '0);
		rx_go_w = (init_mode_r == IMODE_RX) && (THR_W'(rx_level) < rx_thr_r) &&
			(rx_thr_r <= THR_W'(DEPTH));
		// idle mode or zero count waits
		start_w = (st_r == ST_IDLE) && legal_w && (byte_count_r != '0) && (tx_go_w || rx_go_w);
		sh_nxt = sh_r;
		if (rising_w) begin
			sh_nxt = shifted_w;
		end else if (xfer_load_w) begin
			sh_nxt = dir_rx_r ? 8'h00 : tx_q_data;
		end else if (poll_load_w) begin
			sh_nxt = (st_r == ST_POLL_CMD) ? STAT_CMD : 8'h00;
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_r <= ST_IDLE;
			sck_r <= 1'b0;
			cs_n_r <= CS_NONE;
			dev_r <= 1'b0;
			dir_rx_r <= 1'b0;
			lanes_r <= LANE_1;
			bit_cnt_r <= 4'h0;
			bytes_left_r <= '0;
			sh_r <= 8'h00;
		end else begin
			sh_r <= sh_nxt;
			if (falling_w) begin
				sck_r <= 1'b0;
			end else if (rising_w) begin
				sck_r <= 1'b1;
			end
			if (rising_w) begin
				bit_cnt_r <= bit_cnt_r - step_w;
			end else if (xfer_load_w || poll_load_w) begin
				bit_cnt_r <= BYTE_BITS;
				bytes_left_r <= bytes_left_r - 1'b1;
			end
			case (st_r)
				ST_IDLE: if (start_w) begin
					st_r <= ST_XFER;
					cs_n_r <= target_sel_r[0] ? 2'h1 : 2'h2;
					dev_r <= target_sel_r[0];
					dir_rx_r <= init_mode_r == IMODE_RX;
					lanes_r <= lane_width_r;
					bytes_left_r <= byte_count_r;
				end
				ST_XFER: if (end_w) begin
					st_r <= ST_IDLE;
					if (cs_release_r) begin
						cs_n_r <= CS_NONE;
						if (status_check_r) begin
							st_r <= ST_POLL_CMD;
							bytes_left_r <= 16'h0001;
							lanes_r <= LANE_1;
							dir_rx_r <= 1'b0;
						end
					end
				end
				ST_POLL_CMD: if (!cs_act_w) begin
					cs_n_r <= dev_r ? 2'h1 : 2'h2;
				end else if (at_gap_w && bytes_left_r == '0) begin
					st_r <= ST_POLL_DATA;
					bytes_left_r <= 16'h0001;
					dir_rx_r <= 1'b1;
				end
				ST_POLL_DATA: if (at_gap_w && bytes_left_r == '0) begin
					if (sh_r[STAT_BUSY_BIT]) begin
						bytes_left_r <= 16'h0001;
					end else begin
						cs_n_r <= CS_NONE;
						st_r <= ST_IDLE;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// Data changes on the falling edge or on a load, never at a rise
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sqd_o_r <= 4'h0;
			sqd_oe_r <= 4'h0;
			busy_r <= 1'b0;
		end else begin
			if (falling_w || xfer_load_w || poll_load_w) begin
				sqd_o_r <= lane_bits(lanes_r, sh_nxt);
			end
			if (!cs_act_w) begin
				sqd_oe_r <= 4'h0;
			end else if (lanes_r == LANE_1) begin
				sqd_oe_r <= 4'h1;
			end else begin
				sqd_oe_r <= dir_rx_r ? 4'h0 : ((lanes_r == LANE_4) ? 4'hF : 4'h3);
			end
			busy_r <= st_r != ST_IDLE;
		end
	end

	byte_queue #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) tx_q (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.in_data_in(TX_DATA_IN),
		.in_valid_in(TX_VALID_IN),
		.in_ready_out(TX_READY_OUT),
		.out_data_out(tx_q_data),
		.out_valid_out(tx_q_valid),
		.out_ready_in(tx_pop_w),
		.level_out(tx_level)
	);

	byte_queue #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) rx_q (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.in_data_in(shifted_w),
		.in_valid_in(rx_push_w),
		.in_ready_out(rx_in_ready),
		.out_data_out(RX_DATA_OUT),
		.out_valid_out(RX_VALID_OUT),
		.out_ready_in(RX_READY_IN),
		.level_out(rx_level)
	);

	assign REG_RDATA_OUT = rdata_r;
	assign SCK_OUT = sck_r;
	assign CS0_N_OUT = cs_n_r[0];
	assign CS1_N_OUT = cs_n_r[1];
	assign SQD_OUT = sqd_o_r;
	assign SQD_OE_OUT = sqd_oe_r;
	assign BUSY_OUT = busy_r;

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);

	a_idle_no_start: assert property (
		(st_r == ST_IDLE && init_mode_r == IMODE_IDLE) |=> st_r == ST_IDLE)
		else $error("engine left idle in idle mode");
	a_tx_threshold: assert property (
		$rose(busy_r) && !dir_rx_r |-> $past(THR_W'(tx_level), 2) >= $past(tx_thr_r, 2))
		else $error("transmit began below threshold");
	a_rx_room: assert property (
		rx_push_w |-> rx_in_ready)
		else $error("receive byte pushed into full queue");
	a_dev_route: assert property (
		(st_r == ST_IDLE && start_w && target_sel_r == TSEL_DEV1) |=> !CS1_N_OUT && CS0_N_OUT)
		else $error("device 1 not selected");
	a_cs_release: assert property (
		end_w && cs_release_r |=> CS0_N_OUT && CS1_N_OUT)
		else $error("select held despite release policy");
	a_cs_hold: assert property (
		end_w && !cs_release_r |=> !(CS0_N_OUT && CS1_N_OUT) && st_r == ST_IDLE)
		else $error("select dropped despite hold policy");
	a_status_poll: assert property (
		end_w && cs_release_r |=> (st_r == ST_POLL_CMD) == $past(status_check_r))
		else $error("status poll decision wrong");
	a_stable_wait: assert property (
		$rose(clk_en_r) |-> !clk_stable_r [*8])
		else $error("stable flag rose too early");
	a_clock_stop: assert property (
		!clk_en_r |=> !clk_stable_r && $stable(SCK_OUT))
		else $error("serial clock moved while disabled");
	a_half_period: assert property (
		$changed(sck_r) |-> $past(hp_cnt_r) >= $past(hp_w) - 1'b1)
		else $error("serial clock edge before half period");
	a_byte_count: assert property (
		end_w |-> $past(bytes_left_r) == '0 || $past(bit_cnt_r) != 4'h0 || $past(sck_r))
		else $error("transfer ended before its count");

	c_tx_xfer: cover property ($rose(busy_r) && !dir_rx_r);
	c_rx_xfer: cover property (rx_push_w);
	c_poll: cover property (st_r == ST_POLL_DATA && at_gap_w && bytes_left_r == '0);
	c_stall: cover property (st_r == ST_XFER && at_gap_w && bytes_left_r != '0 && !xfer_load_w);
endmodule // quad_serial_flash_control

// ---- testbench/flash_model.sv ----
// Behavioural serial flash on one to four data lanes.
// Assumes the bench gives the lane width and whether data phases read.
module flash_model #(
	parameter int BUSY_READS = 2
) (
	input wire logic sck_in, // Serial clock
	input wire logic cs0_n_in, // Device 0 select
	input wire logic cs1_n_in, // Device 1 select
	input wire logic [3:0] dat_in, // Lane levels
	input wire logic [1:0] lanes_in, // Lane width
	input wire logic rd_in, // Data phase reads
	output logic [3:0] dat_out // Lanes driven back
);
	timeunit 1ns;
	timeprecision 1ps;
	logic idle;
	logic [7:0] sh = 8'h00, rb = 8'hC3, nxt = 8'hC3, cur;
	logic [3:0] drv = 4'h0;
	int bc = 0, w, busy_left = BUSY_READS, stat_n = 0;
	bit first = 1, poll = 0;
	logic [7:0] got[$], sent[$];
	assign idle = cs0_n_in & cs1_n_in;
	assign w = poll ? 1 : (1 << lanes_in);
	// Released lanes show the inverse of the last level
	assign dat_out = idle ? ~drv : drv;
	always @(posedge sck_in or posedge idle) begin
		if (idle) begin
			bc = 0;
			first = 1;
			poll = 0;
			rb = nxt;
		end else if (rd_in || (poll && !first)) begin
			bc += w;
			if (bc == 8) begin
				bc = 0;
				if (poll) begin
					stat_n++;
					if (busy_left > 0) busy_left--;
				end else begin
					sent.push_back(rb);
					nxt += 8'h11;
				end
				rb = poll ? {7'h00, busy_left > 0} : nxt;
			end
		end else begin
			sh = (sh << w) | (dat_in & ((8'h01 << w) - 8'h01));
			bc += w;
			if (bc == 8) begin
				bc = 0;
				got.push_back(sh);
				if (first && sh == 8'h05) begin
					poll = 1;
					rb = {7'h00, busy_left > 0};
				end
				first = 0;
			end
		end
	end
	// New bits at the falling clock edge and when a select asserts
	always @(negedge sck_in or negedge idle) begin
		cur = (rb >> (8 - bc - w)) & ((8'h01 << w) - 8'h01);
		drv <= (w == 1) ? {2'h0, cur[0], 1'h0} : cur[3:0];
	end
endmodule // flash_model

// ---- testbench/tb_quad_serial_flash_control.sv ----
// Self-checking bench for the quad serial flash control block.
// Assumes the flash model on the lanes and a shortened clock settle time.
module tb_quad_serial_flash_control import qsf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, wr, rd, tx_valid, tx_ready, rx_valid, rx_ready, sck, cs0, cs1, busy, rd_mode;
	logic [1:0] addr, lanes;
	logic [31:0] wdata, rdata;
	logic [7:0] tx_data, rx_data;
	logic [3:0] sqd_out, sqd_oe, fl_dat, sqd_wire;
	int err_total = 0, total_checks = 0, cyc = 0, hi_run = 0, hp = 0;
	bit saw0, saw1;
	assign sqd_wire = (sqd_oe & sqd_out) | (~sqd_oe & fl_dat);
	quad_serial_flash_control #(.SETTLE(8)) u_quad_serial_flash_control (
		.CLOCK_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
		.TX_DATA_IN(tx_data), .TX_VALID_IN(tx_valid), .TX_READY_OUT(tx_ready),
		.RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid), .RX_READY_IN(rx_ready),
		.SCK_OUT(sck), .CS0_N_OUT(cs0), .CS1_N_OUT(cs1), .SQD_IN(sqd_wire),
		.SQD_OUT(sqd_out), .SQD_OE_OUT(sqd_oe), .BUSY_OUT(busy));
	flash_model u_flash_model (.sck_in(sck), .cs0_n_in(cs0), .cs1_n_in(cs1),
		.dat_in(sqd_wire), .lanes_in(lanes), .rd_in(rd_mode), .dat_out(fl_dat));
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Watchdog, select usage and serial clock high time
	always @(negedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			wrap_up();
		end
		if (!cs0) saw0 = 1;
		if (!cs1) saw1 = 1;
		if (sck) hi_run++;
		else if (hi_run > 0) begin
			hp = hi_run;
			hi_run = 0;
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
		@(negedge clk);
		wr = 1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 0;
	endtask
	task automatic rchk(input string nm, input logic [1:0] a, input logic [31:0] e);
		@(negedge clk);
		rd = 1;
		addr = a;
		@(negedge clk);
		rd = 0;
		@(negedge clk);
		chk(nm, rdata, e);
	endtask
	task automatic push(input logic [7:0] b);
		int n;
		@(negedge clk);
		tx_data = b;
		tx_valid = 1;
		for (n = 0; n < 5000 && !tx_ready; n++) @(negedge clk);
		@(negedge clk);
		tx_valid = 0;
	endtask
	task automatic pop(output logic [7:0] b);
		int n;
		@(negedge clk);
		for (n = 0; n < 50 && !rx_valid; n++) @(negedge clk);
		b = rx_data;
		rx_ready = 1;
		@(negedge clk);
		rx_ready = 0;
	endtask
	task automatic wait_idle(input int lim);
		int q;
		q = 0;
		for (int n = 0; n < 20 && !busy; n++) @(negedge clk);
		for (int n = 0; n < lim && q < 4; n++) begin
			@(negedge clk);
			q = busy ? 0 : q + 1;
		end
		chk("idle", q, 4);
	endtask
	task automatic reg_run();
		chk("reset pins", {cs0, cs1, tx_ready, sck, busy, rx_valid}, 6'h38);
		rchk("control reset", IDX_XCTL, 32'h0);
		rchk("clock reset", IDX_CKCTL, 32'h0);
		rchk("threshold reset", IDX_THR, 32'h0);
		reg_wr(IDX_XCTL, 32'hFFFF_FFFF);
		rchk("control bits", IDX_XCTL, 32'h017F_FFFF);
		reg_wr(IDX_CKCTL, 32'hFFFF_FFFF);
		repeat (10) @(negedge clk);
		rchk("clock bits", IDX_CKCTL, 32'h0007_FF03);
		reg_wr(IDX_THR, 32'hFFFF_FFFF);
		rchk("threshold bits", IDX_THR, 32'h0000_FFFF);
		reg_wr(2'h3, 32'hFFFF_FFFF);
		rchk("unmapped", 2'h3, 32'h0);
		reg_wr(IDX_CKCTL, 32'h0);
		rchk("clock off", IDX_CKCTL, 32'h0);
	endtask
	task automatic tx_run(input logic [1:0] ln, ts, input logic [10:0] dv, input int hpe);
		lanes = ln;
		rd_mode = 0;
		u_flash_model.got.delete();
		saw0 = 0;
		saw1 = 0;
		reg_wr(IDX_CKCTL, {13'h0, dv, 8'h01});
		reg_wr(IDX_THR, 32'h0000_0200);
		reg_wr(IDX_XCTL, {9'h0, 1'h1, ts, ln, IMODE_TX, 16'h0002});
		push(8'h3C);
		repeat (12) @(negedge clk);
		chk("early start", {busy, cs0, cs1}, 3'h3);
		push(8'hA9);
		wait_idle(40000);
		chk("byte total", u_flash_model.got.size(), 2);
		chk("byte 0", u_flash_model.got[0], 8'h3C);
		chk("byte 1", u_flash_model.got[1], 8'hA9);
		chk("target", {saw1, saw0}, (ts == TSEL_DEV0) ? 2'h1 : 2'h2);
		chk("select end", {cs0, cs1}, 2'h3);
		chk("half period", hp, hpe);
	endtask
	task automatic keep_select();
		u_flash_model.got.delete();
		reg_wr(IDX_CKCTL, 32'h0000_0001);
		reg_wr(IDX_THR, 32'h0000_0100);
		reg_wr(IDX_XCTL, {9'h0, 1'h0, TSEL_DEV1, LANE_2, IMODE_TX, 16'h0001});
		lanes = LANE_2;
		push(8'h5A);
		wait_idle(2000);
		chk("select kept", {cs0, cs1}, 2'h2);
		reg_wr(IDX_XCTL, {9'h0, 1'h1, TSEL_DEV1, LANE_2, IMODE_TX, 16'h0001});
		push(8'h96);
		wait_idle(2000);
		chk("select freed", {cs0, cs1}, 2'h3);
		chk("frame", {u_flash_model.got[0], u_flash_model.got[1]}, 16'h5A96);
	endtask
	task automatic idle_fill();
		logic [31:0] bad[4] = '{32'h0043_0008, 32'h004D_0008, 32'h0061_0008, 32'h0071_0008};
		u_flash_model.got.delete();
		lanes = LANE_1;
		reg_wr(IDX_XCTL, 32'h0040_0008);
		for (int i = 0; i < 8; i++) push(8'h10 + i[7:0]);
		@(negedge clk);
		chk("queue full", {tx_ready, busy, cs0}, 3'h1);
		foreach (bad[k]) begin
			reg_wr(IDX_XCTL, bad[k]);
			repeat (20) @(negedge clk);
			chk("reserved code", {busy, cs0, cs1}, 3'h3);
		end
		reg_wr(IDX_XCTL, 32'h0041_0008);
		wait_idle(2000);
		chk("drained", tx_ready, 1'h1);
		chk("drain total", u_flash_model.got.size(), 8);
		chk("last byte", u_flash_model.got[7], 8'h17);
	endtask
	task automatic rx_run();
		logic [7:0] b;
		lanes = LANE_2;
		rd_mode = 1;
		u_flash_model.sent.delete();
		reg_wr(IDX_CKCTL, 32'h0000_0401);
		reg_wr(IDX_THR, 32'h0000_0003);
		reg_wr(IDX_XCTL, {9'h0, 1'h1, TSEL_DEV0, LANE_2, IMODE_RX, 16'h0003});
		wait_idle(4000);
		repeat (20) @(negedge clk);
		chk("fetch held", {busy, cs0}, 2'h1);
		chk("fetched", u_flash_model.sent.size(), 3);
		pop(b);
		chk("rx byte", b, u_flash_model.sent[0]);
		wait_idle(4000);
		chk("refetch", u_flash_model.sent.size(), 6);
		reg_wr(IDX_XCTL, 32'h0040_0000);
		for (int i = 1; i < 6; i++) begin
			pop(b);
			chk("rx byte", b, u_flash_model.sent[i]);
		end
		chk("rx empty", rx_valid, 1'h0);
		rd_mode = 0;
	endtask
	task automatic status_run();
		lanes = LANE_1;
		u_flash_model.got.delete();
		reg_wr(IDX_THR, 32'h0000_0100);
		reg_wr(IDX_XCTL, 32'h0141_0001);
		push(8'hE7);
		wait_idle(8000);
		chk("poll reads", u_flash_model.stat_n, 3);
		chk("poll command", u_flash_model.got[1], 8'h05);
		chk("poll end", {cs0, cs1}, 2'h3);
	endtask
	initial begin
		rst = 1;
		wr = 0;
		rd = 0;
		addr = 2'h0;
		wdata = 32'h0;
		tx_data = 8'h00;
		tx_valid = 0;
		rx_ready = 0;
		lanes = 2'h0;
		rd_mode = 0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 0;
		reg_run();
		for (int l = 0; l < 3; l++)
			for (int t = 0; t < 2; t++)
				tx_run(l[1:0], t[1:0], 11'h000, 1);
		tx_run(LANE_1, TSEL_DEV0, 11'h001, 1);
		tx_run(LANE_1, TSEL_DEV0, 11'h002, 2);
		tx_run(LANE_1, TSEL_DEV0, 11'h00C, 8);
		tx_run(LANE_1, TSEL_DEV0, 11'h400, 1024);
		keep_select();
		idle_fill();
		rx_run();
		status_run();
		wrap_up();
	end
endmodule // tb_quad_serial_flash_control
